// ---- logic/acs_params.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
`define ACS_ADDR_CONV_CTRL   8'hd8
`define ACS_ADDR_MODE_CTRL   8'hef
`define ACS_ADDR_BUSY_STAT   8'hf5
`define ACS_ADDR_IRQ_STAT    8'he1
`define ACS_ADDR_IRQ_MASK    8'he2
`define ACS_ADDR_DMA_CHAN    8'he3
`define ACS_ADDR_DMA_CTRL    8'he4
`define ACS_BITOP_WIDTH      3
`define ACS_RST_CONV_CTRL    8'h00
`define ACS_RST_MODE_CTRL    8'h20
`define ACS_RST_IRQ_MASK     8'h00
`define ACS_CONV_CLKS        5'h11
`define ACS_CHAN_TEMP        4'h8
`define ACS_CHAN_DMA_STOP    4'hf
`define ACS_BIT_DONE         7
`define ACS_BIT_DMA          6
`define ACS_BIT_CONT         5
`define ACS_BIT_SINGLE       4
`define ACS_BIT_TIMER_EN     1
`define ACS_BIT_EXT_EN       0
`define ACS_IRQ_DONE         0
`define ACS_IRQ_BLOCK        1
`define ACS_IRQ_SPURIOUS     2
`endif

// ---- logic/acs_pkg.sv ----
// Types shared by the conversion sequencer
package acs_pkg;
  typedef enum logic [4:0] {
    ACS_IDLE    = 5'b00001,
    ACS_WAKE    = 5'b00010,
    ACS_ACQUIRE = 5'b00100,
    ACS_CONVERT = 5'b01000,
    ACS_FINISH  = 5'b10000
  } acs_state_t;
  typedef enum logic [1:0] {
    ACS_PWR_DOWN     = 2'b00,
    ACS_PWR_NORMAL   = 2'b01,
    ACS_PWR_DOWN_IDL = 2'b10,
    ACS_PWR_STBY_IDL = 2'b11
  } acs_pwr_t;
endpackage

// ---- logic/acs_clk_div.sv ----
// Divider making the one-cycle ADC clock enable from the master clock
`timescale 1ns/1ps
`default_nettype none
module acs_clk_div
  import acs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [1:0] div_sel,
  output var  logic       tick
);
  logic [2:0] count_reg;
  logic [2:0] limit;
  logic       wrap;
  // Divide by 1, 2, 4 or 8
  assign limit = 3'((4'h1 << div_sel) - 4'h1);
  assign wrap  = (count_reg >= limit);
  always_ff @(posedge mclk)
  begin
    if (reset || !run)
    begin
      count_reg <= 3'h0;
      tick      <= 1'b0;
    end
    else
    begin
      count_reg <= wrap ? 3'h0 : 3'(count_reg + 3'h1);
      tick      <= wrap;
    end
  end
endmodule
`default_nettype wire

// ---- logic/acs_sequencer.sv ----
// ADC conversion sequencer: registers, triggers, timing and done events
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output var  logic [7:0] reg_rdata,
  input  wire logic       bit_write,
  input  wire logic [2:0] bit_index,
  input  wire logic       bit_value,
  input  wire logic       timer_overflow,
  input  wire logic       convert_start_pin,
  input  wire logic       isr_vector,
  input  wire logic [3:0] dma_entry_chan,
  output var  logic       dma_entry_req,
  output var  logic       adc_power_on,
  output var  logic       adc_standby,
  output var  logic       adc_track,
  output var  logic       adc_convert,
  output var  logic [3:0] adc_channel,
  output var  logic       conversion_done_flag,
  output var  logic       irq
);
  logic [7:0] conv_ctrl_reg;
  logic [7:0] conv_ctrl_next;
  logic [7:0] mode_ctrl_reg;
  logic [7:0] irq_stat_reg;
  logic [7:0] irq_stat_next;
  logic [7:0] irq_mask_reg;
  logic       pin_prev_reg;
  logic       timer_armed_reg;
  logic       busy_reg;
  logic       dma_block_reg;
  logic [4:0] count_reg;
  logic [4:0] count_next;
  acs_state_t state_reg;
  acs_state_t state_next;
  logic [1:0] power_mode;
  logic [1:0] clock_div;
  logic [1:0] acquire_time;
  logic       timer_trigger_en;
  logic       external_trigger_en;
  logic       dma_en;
  logic       continuous_conversion_en;
  logic       single_conversion_start;
  logic [3:0] channel_select;
  logic       wr_conv;
  logic       wr_mode;
  logic       wr_istat;
  logic       wr_imask;
  logic       bit_conv;
  logic       adc_tick;
  logic       div_run;
  logic       pin_rise;
  logic       timer_start;
  logic       ext_start;
  logic       sw_start;
  logic       start_req;
  logic       start_take;
  logic       spurious;
  logic       conv_end;
  logic       chan_stop;
  logic       chan_reserved;
  logic [3:0] chan_pick;
  logic [4:0] acq_clks;
  logic       ev_done;
  logic       ev_block;
  logic [7:0] rdata_next;

  assign power_mode               = mode_ctrl_reg[7:6];
  assign clock_div                = mode_ctrl_reg[5:4];
  assign acquire_time             = mode_ctrl_reg[3:2];
  assign timer_trigger_en         = mode_ctrl_reg[`ACS_BIT_TIMER_EN];
  assign external_trigger_en      = mode_ctrl_reg[`ACS_BIT_EXT_EN];
  assign dma_en                   = conv_ctrl_reg[`ACS_BIT_DMA];
  assign continuous_conversion_en = conv_ctrl_reg[`ACS_BIT_CONT];
  assign single_conversion_start  = conv_ctrl_reg[`ACS_BIT_SINGLE];
  assign channel_select           = conv_ctrl_reg[3:0];

  assign wr_conv  = reg_write && (reg_addr == `ACS_ADDR_CONV_CTRL);
  assign wr_mode  = reg_write && (reg_addr == `ACS_ADDR_MODE_CTRL);
  assign wr_istat = reg_write && (reg_addr == `ACS_ADDR_IRQ_STAT);
  assign wr_imask = reg_write && (reg_addr == `ACS_ADDR_IRQ_MASK);
  assign bit_conv = bit_write && !reg_write;

  assign pin_rise  = convert_start_pin && !pin_prev_reg;
  assign ext_start = external_trigger_en && pin_rise;
  // first overflow arms, later ones start
  assign timer_start = timer_trigger_en && timer_overflow && timer_armed_reg;
  // continuous and DMA bits restart after finish
  assign sw_start  = single_conversion_start || continuous_conversion_en
                   || dma_en;
  assign start_req = ext_start || timer_start || sw_start;
  // no start while busy
  // The list entry moves one cycle after the advance pulse, so wait for it
  assign start_take = start_req && !busy_reg
                   && !(dma_en && dma_entry_req)
                   && (power_mode != ACS_PWR_DOWN);
  assign spurious  = (ext_start || timer_start) && busy_reg;

  assign chan_pick = dma_en ? dma_entry_chan : channel_select;
  assign chan_stop     = (chan_pick == `ACS_CHAN_DMA_STOP);
  assign chan_reserved = (chan_pick > `ACS_CHAN_TEMP) && !chan_stop;

  assign acq_clks = 5'(5'h1 << acquire_time);
  assign conv_end = (state_reg == ACS_FINISH);

  assign div_run = (state_reg != ACS_IDLE);
  acs_clk_div u_div (
    .mclk    (mclk),
    .reset   (reset),
    .run     (div_run),
    .div_sel (clock_div),
    .tick    (adc_tick)
  );

  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      ACS_IDLE:
      begin
        // Stop marker and reserved codes never start a cycle
        if (start_take && !chan_stop && !chan_reserved)
        begin
          state_next = ACS_WAKE;
          count_next = 5'h0;
        end
      end
      ACS_WAKE:
      begin
        if (adc_tick)
        begin
          state_next = ACS_ACQUIRE;
          count_next = 5'h1;
        end
      end
      ACS_ACQUIRE:
      begin
        if (adc_tick)
        begin
          if (count_reg >= acq_clks)
          begin
            state_next = ACS_CONVERT;
            count_next = 5'h1;
          end
          else
            count_next = 5'(count_reg + 5'h1);
        end
      end
      ACS_CONVERT:
      begin
        if (adc_tick)
        begin
          if (count_reg >= `ACS_CONV_CLKS)
            state_next = ACS_FINISH;
          else
            count_next = 5'(count_reg + 5'h1);
        end
      end
      ACS_FINISH:
        state_next = ACS_IDLE;
      default:
        state_next = ACS_IDLE;
    endcase
  end

  // Block ends when DMA mode meets the stop marker or is switched off
  assign ev_done  = conv_end && !dma_block_reg;
  assign ev_block = dma_block_reg && (state_reg == ACS_IDLE)
                 && ((dma_en && chan_stop) || !dma_en);

  always_comb
  begin
    conv_ctrl_next = conv_ctrl_reg;
    if (wr_conv)
      conv_ctrl_next = reg_wdata;
    else if (bit_conv && (reg_addr == `ACS_ADDR_CONV_CTRL))
      conv_ctrl_next[bit_index] = bit_value;
    if (conv_end && single_conversion_start)
      conv_ctrl_next[`ACS_BIT_SINGLE] = 1'b0;
    if (isr_vector)
      conv_ctrl_next[`ACS_BIT_DONE] = 1'b0;
    if (ev_done || ev_block)
      conv_ctrl_next[`ACS_BIT_DONE] = 1'b1;
    if (ev_block && dma_en)
      conv_ctrl_next[`ACS_BIT_DMA] = 1'b0;
  end

  always_comb
  begin
    irq_stat_next = irq_stat_reg;
    if (wr_istat)
      irq_stat_next = irq_stat_reg & ~reg_wdata;
    if (ev_done)
      irq_stat_next[`ACS_IRQ_DONE] = 1'b1;
    if (ev_block)
      irq_stat_next[`ACS_IRQ_BLOCK] = 1'b1;
    if (spurious)
      irq_stat_next[`ACS_IRQ_SPURIOUS] = 1'b1;
  end

  always_comb
  begin
    rdata_next = 8'h00;
    case (reg_addr)
      `ACS_ADDR_CONV_CTRL: rdata_next = conv_ctrl_reg;
      `ACS_ADDR_MODE_CTRL: rdata_next = mode_ctrl_reg;
      `ACS_ADDR_BUSY_STAT: rdata_next = {busy_reg, 7'h00};
      `ACS_ADDR_IRQ_STAT:  rdata_next = irq_stat_reg;
      `ACS_ADDR_IRQ_MASK:  rdata_next = irq_mask_reg;
      `ACS_ADDR_DMA_CHAN:  rdata_next = {4'h0, dma_entry_chan};
      `ACS_ADDR_DMA_CTRL:  rdata_next = {7'h00, dma_block_reg};
      default:             rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      conv_ctrl_reg <= `ACS_RST_CONV_CTRL;
      mode_ctrl_reg <= `ACS_RST_MODE_CTRL;
      irq_stat_reg  <= 8'h00;
      irq_mask_reg  <= `ACS_RST_IRQ_MASK;
      reg_rdata     <= 8'h00;
    end
    else
    begin
      conv_ctrl_reg <= conv_ctrl_next;
      irq_stat_reg  <= irq_stat_next;
      reg_rdata     <= reg_read ? rdata_next : 8'h00;
      if (wr_mode)
        mode_ctrl_reg <= reg_wdata;
      else if (bit_conv && (reg_addr == `ACS_ADDR_MODE_CTRL))
        mode_ctrl_reg[bit_index] <= bit_value;
      if (wr_imask)
        irq_mask_reg <= reg_wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_reg       <= ACS_IDLE;
      count_reg       <= 5'h00;
      pin_prev_reg    <= 1'b1;
      timer_armed_reg <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      count_reg    <= count_next;
      pin_prev_reg <= convert_start_pin;
      // arm after first overflow once enabled
      if (!timer_trigger_en)
        timer_armed_reg <= 1'b0;
      else if (timer_overflow)
        timer_armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      busy_reg             <= 1'b0;
      dma_block_reg        <= 1'b0;
      dma_entry_req        <= 1'b0;
      adc_power_on         <= 1'b0;
      adc_standby          <= 1'b0;
      adc_track            <= 1'b0;
      adc_convert          <= 1'b0;
      adc_channel          <= 4'h0;
      conversion_done_flag <= 1'b0;
      irq                  <= 1'b0;
    end
    else
    begin
      busy_reg <= (state_next != ACS_IDLE);
      if (ev_block)
        dma_block_reg <= 1'b0;
      else if (dma_en && start_take && !chan_stop)
        dma_block_reg <= 1'b1;
      dma_entry_req <= conv_end && dma_block_reg;
      if ((state_reg == ACS_IDLE) && (state_next == ACS_WAKE))
        adc_channel <= chan_pick;
      case (power_mode)
        ACS_PWR_NORMAL:   adc_power_on <= 1'b1;
        ACS_PWR_DOWN_IDL: adc_power_on <= (state_next != ACS_IDLE);
        ACS_PWR_STBY_IDL: adc_power_on <= (state_next != ACS_IDLE);
        default:          adc_power_on <= 1'b0;
      endcase
      adc_standby <= (power_mode == ACS_PWR_STBY_IDL)
                  && (state_next == ACS_IDLE);
      adc_track   <= (state_next == ACS_ACQUIRE);
      adc_convert <= (state_next == ACS_CONVERT);
      conversion_done_flag <= conv_ctrl_next[`ACS_BIT_DONE];
      irq <= |(irq_stat_next & irq_mask_reg);
    end
  end
endmodule
`default_nettype wire

// ---- test/acs_partner.sv ----
// Trigger sources and DMA channel list facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_partner
(
  input  wire logic       mclk,
  input  wire logic       fire_t,
  input  wire logic       fire_p,
  input  wire logic       dma_entry_req,
  output var  logic       timer_overflow,
  output var  logic       convert_start_pin,
  output var  logic [3:0] dma_entry_chan
);
  logic       t_q   = 1'b0;
  logic [4:0] low_q = 5'h00;
  logic [1:0] idx_q = 2'h0;
  logic [3:0] list_q [4] = '{4'h5, 4'h6, 4'hf, 4'hf};
  always @(posedge mclk)
    t_q <= fire_t;
  // low pulse of 30 cycles, well over the minimum width
  always @(posedge mclk)
    low_q <= fire_p ? 5'h1e : low_q - 5'(low_q != 5'h00);
  // list ends in a stop marker
  always @(posedge mclk)
    idx_q <= idx_q + 2'(dma_entry_req);
  assign timer_overflow    = t_q;
  assign convert_start_pin = low_q == 5'h00;
  assign dma_entry_chan    = list_q[idx_q];
endmodule
`default_nettype wire

// ---- test/acs_sequencer_assertions.sv ----
// Port-level assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_assertions
(
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       isr_vector,
  input wire logic       adc_power_on,
  input wire logic       adc_track,
  input wire logic       adc_convert,
  input wire logic       conversion_done_flag
);
  logic [7:0] conv_q;
  logic [6:0] trk_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Length of the run now ending, any divider
  always_ff @(posedge mclk)
  begin
    conv_q <= adc_convert ? conv_q + 8'h01 : 8'h00;
    trk_q  <= adc_track ? trk_q + 7'h01 : 7'h00;
  end
  a_conv_length: assert property (
    $fell(adc_convert) |-> conv_q >= 8'h11 && conv_q <= 8'h88)
    else $error("conversion length out of range");
  a_acq_length: assert property (
    $fell(adc_track) |-> trk_q >= 7'h01 && trk_q <= 7'h40)
    else $error("acquisition length out of range");
  a_power_active: assert property (
    adc_track || adc_convert |-> adc_power_on)
    else $error("converter active while powered down");
  a_done_cause: assert property (
    $rose(conversion_done_flag) |-> $past(adc_convert)
    || $past(adc_convert, 2) || $past(adc_convert, 3)
    || $past(adc_convert, 4))
    else $error("done flag without a conversion");
  a_isr_clear: assert property (
    isr_vector && conversion_done_flag && !adc_convert
    |=> !conversion_done_flag)
    else $error("done flag kept after vectoring");
  a_busy_read: assert property (
    reg_read && reg_addr == 8'hf5 && adc_convert |=> reg_rdata[7])
    else $error("busy low during conversion");
  a_status_low: assert property (
    reg_read && reg_addr == 8'hf5 |=> reg_rdata[6:0] == 7'h00)
    else $error("reserved status bits not zero");
  a_mode_keep: assert property (
    reg_write && reg_addr == 8'hef ##1 !reg_write ##1 reg_read
    && reg_addr == 8'hef |=> reg_rdata == $past(reg_wdata, 3))
    else $error("mode register readback wrong");
endmodule
bind acs_sequencer acs_sequencer_assertions acs_sequencer_assertions_inst
(
  .mclk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .isr_vector, .adc_power_on, .adc_track, .adc_convert,
  .conversion_done_flag
);
`default_nettype wire

// ---- test/acs_sequencer_test.sv ----
// Register-level test of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_test;
  logic       mclk, reset, reg_write, reg_read, bit_write, bit_value;
  logic       isr_vector, fire_t, fire_p, timer_overflow, convert_start_pin;
  logic       dma_entry_req, adc_power_on, adc_standby, adc_track;
  logic       adc_convert, done, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] dma_entry_chan, adc_channel;
  logic [2:0] bit_index;
  int         fails, check_count, n, k, tc, cc;
  acs_sequencer acs_sequencer_inst (.mclk, .reset, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .bit_write, .bit_index, .bit_value,
    .timer_overflow, .convert_start_pin, .isr_vector, .dma_entry_chan,
    .dma_entry_req, .adc_power_on, .adc_standby, .adc_track, .adc_convert,
    .adc_channel, .conversion_done_flag(done), .irq);
  acs_partner acs_partner_inst (.mclk, .fire_t, .fire_p, .dma_entry_req,
    .timer_overflow, .convert_start_pin, .dma_entry_chan);
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string w, input logic [7:0] s, e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic rd_chk(input string w, input logic [7:0] a, e);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 chk(w, reg_rdata, e);
  endtask
  // Counts acquisition and conversion cycles up to the done flag
  task automatic till_done;
    n  = 0;
    tc = 0;
    cc = 0;
    while (done !== 1'b1 && n < 2000)
    begin
      @(posedge mclk);
      n++;
      tc += adc_track;
      cc += adc_convert;
    end
    chk("done", 8'(done), 8'h01);
  endtask
  task automatic ack;
    @(posedge mclk);
    isr_vector <= 1'b1;
    @(posedge mclk);
    isr_vector <= 1'b0;
    wr(8'he1, 8'h07);
    chk("flag", 8'(done), 8'h00);
  endtask
  task automatic fire(input logic t);
    @(posedge mclk);
    fire_t <= t;
    fire_p <= !t;
    @(posedge mclk);
    fire_t <= 1'b0;
    fire_p <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    fails++;
    summarize;
  end
  initial
  begin
    {reset, reg_write, reg_read, bit_write, bit_value} = 5'h1_0;
    {isr_vector, fire_t, fire_p, bit_index} = 6'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rd_chk("ctrl", 8'hd8, 8'h00);
    rd_chk("mode", 8'hef, 8'h20);
    rd_chk("busy", 8'hf5, 8'h00);
    rd_chk("none", 8'h10, 8'h00);
    wr(8'he2, 8'h01);
    for (k = 0; k < 4; k++)
    begin
      wr(8'hef, 8'(8'h40 + k * 8'h14));
      rd_chk("mode", 8'hef, 8'(8'h40 + k * 8'h14));
      wr(8'hd8, 8'h13);
      till_done;
      chk("acq", 8'(tc), 8'(1 << (2 * k)));
      chk("conv", 8'(cc), 8'(17 << k));
      chk("chan", 8'(adc_channel), 8'h03);
      rd_chk("ctrl", 8'hd8, 8'h83);
      chk("irq", 8'(irq), 8'h01);
      ack;
      rd_chk("stat", 8'he1, 8'h00);
      chk("irq", 8'(irq), 8'h00);
    end
    wr(8'hd8, 8'h18);
    rd_chk("busy", 8'hf5, 8'h80);
    till_done;
    chk("chan", 8'(adc_channel), 8'h08);
    rd_chk("busy", 8'hf5, 8'h00);
    ack;
    wr(8'hd8, 8'h19);
    repeat (30) @(posedge mclk);
    rd_chk("busy", 8'hf5, 8'h00);
    wr(8'hd8, 8'h02);
    @(posedge mclk);
    reg_addr  <= 8'hd8;
    bit_index <= 3'h4;
    bit_value <= 1'b1;
    bit_write <= 1'b1;
    @(posedge mclk);
    bit_write <= 1'b0;
    till_done;
    chk("chan", 8'(adc_channel), 8'h02);
    ack;
    // Second pin pulse lands while the first conversion is still busy
    wr(8'hef, 8'h71);
    wr(8'hd8, 8'h01);
    fire(1'b0);
    repeat (20) @(posedge mclk);
    chk("track", 8'(adc_track), 8'h00);
    repeat (20) @(posedge mclk);
    fire(1'b0);
    till_done;
    chk("chan", 8'(adc_channel), 8'h01);
    rd_chk("stat", 8'he1, 8'h05);
    ack;
    wr(8'hef, 8'h42);
    wr(8'hd8, 8'h04);
    fire(1'b1);
    repeat (10) @(posedge mclk);
    rd_chk("busy", 8'hf5, 8'h00);
    fire(1'b1);
    till_done;
    chk("chan", 8'(adc_channel), 8'h04);
    ack;
    wr(8'hd8, 8'h26);
    cc = 0;
    repeat (100)
    begin
      @(posedge mclk);
      cc += adc_convert;
    end
    chk("cont", 8'(cc > 60), 8'h01);
    wr(8'hd8, 8'h06);
    repeat (40) @(posedge mclk);
    ack;
    wr(8'hd8, 8'h40);
    till_done;
    chk("dma", 8'(cc), 8'h22);
    chk("chan", 8'(adc_channel), 8'h06);
    rd_chk("ctrl", 8'hd8, 8'h80);
    rd_chk("stat", 8'he1, 8'h02);
    ack;
    wr(8'hef, 8'hc0);
    repeat (3) @(posedge mclk);
    chk("stby", 8'(adc_standby), 8'h01);
    chk("pwr", 8'(adc_power_on), 8'h00);
    wr(8'hd8, 8'h10);
    till_done;
    ack;
    chk("pwr", 8'(adc_power_on), 8'h00);
    wr(8'hef, 8'h80);
    wr(8'hd8, 8'h10);
    repeat (2) @(posedge mclk);
    #1 chk("pwr", 8'(adc_power_on), 8'h01);
    chk("stby", 8'(adc_standby), 8'h00);
    till_done;
    ack;
    chk("pwr", 8'(adc_power_on), 8'h00);
    wr(8'hef, 8'h00);
    wr(8'hd8, 8'h10);
    repeat (30) @(posedge mclk);
    rd_chk("busy", 8'hf5, 8'h00);
    summarize;
  end
endmodule
`default_nettype wire
